/* core/etsr_regs.vh */
// register map, field positions and timing figures of the timestamp sample records
// assumes byte addressing on a 32-bit avalon-mm slave port
`ifndef ETSR_REGS_VH
`define ETSR_REGS_VH

`define ETSR_ADDR_W 12
`define ETSR_OFS_S5_SEC 12'h588
`define ETSR_OFS_S5_PHASE 12'h58c
`define ETSR_OFS_S6_NS 12'h590
`define ETSR_OFS_S6_SEC 12'h594
`define ETSR_OFS_S6_PHASE 12'h598
`define ETSR_OFS_S7_NS 12'h59c
`define ETSR_OFS_UNIT_INDEX 12'h520
`define ETSR_OFS_CAPTURE_STATUS 12'h524

`define ETSR_UNIT_PTR_BIT 8
`define ETSR_RESTART_BIT 0
`define ETSR_NS_POL_BIT 30
`define ETSR_NS_MSB 29
`define ETSR_SLOT_MSB 2
`define ETSR_RESET_WORD 32'h00000000

`define ETSR_SLOT_NS 8
`define ETSR_BASE_PERIOD_NS 40
`define ETSR_CLK_PERIOD_NS 8
`define ETSR_SLOT_CYCLES (`ETSR_SLOT_NS / `ETSR_CLK_PERIOD_NS)
`define ETSR_SLOTS_PER_PERIOD (`ETSR_BASE_PERIOD_NS / `ETSR_SLOT_NS)

`define ETSR_CODE_0NS 3'h0
`define ETSR_CODE_8NS 3'h1
`define ETSR_CODE_16NS 3'h2
`define ETSR_CODE_24NS 3'h3
`define ETSR_CODE_32NS 3'h4

`define ETSR_NUM_UNITS 2
`define ETSR_NUM_SAMPLES 3

`endif

/* core/etsr_slot_enc.v */
// slot index to phase code encoder, registered
// assumes slot index 0..4 counted by the top on the 125 mhz clock
`timescale 1ns/1ps
`include "etsr_regs.vh"

module etsr_slot_enc (
    // clock and reset
    input wire ref_clk_in,
    input wire reset_n_in,
    // slot index within the 40 ns period
    input wire [2:0] slot_in,
    // encoded phase
    output reg [2:0] code_out
);

    function [2:0] etsr_encode;
        input [2:0] slot;
        begin
            case (slot)
                3'h0: etsr_encode = `ETSR_CODE_0NS;
                3'h1: etsr_encode = `ETSR_CODE_8NS;
                // third slot uses 010, the free code, not the reserved 101
                3'h2: etsr_encode = `ETSR_CODE_16NS;
                3'h3: etsr_encode = `ETSR_CODE_24NS;
                3'h4: etsr_encode = `ETSR_CODE_32NS;
                default: etsr_encode = `ETSR_CODE_0NS;
            endcase
        end
    endfunction

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            code_out <= 3'h0;
        end else begin
            code_out <= etsr_encode(slot_in); // R06 R07 R08
        end
    end

endmodule

/* core/etsr_capture.v */
// one timestamp unit: holds the fifth, sixth and seventh sample records
// assumes edge pulse, polarity and time are aligned in the same cycle
`timescale 1ns/1ps
`include "etsr_regs.vh"

module etsr_capture (
    // clock and reset
    input wire ref_clk_in,
    input wire reset_n_in,
    // capture request
    input wire edge_in,
    input wire polarity_in,
    input wire restart_in,
    // current time
    input wire [31:0] sec_in,
    input wire [29:0] nanos_in,
    input wire [2:0] slot_code_in,
    // stored records, index 0 is the fifth sample
    output wire [95:0] sec_out,
    output wire [89:0] nanos_out,
    output wire [2:0] pol_out,
    output wire [8:0] slot_out,
    output reg [1:0] count_out
);

    // each record owns its registers, so no variable has two processes driving it
    genvar g;
    generate
        for (g = 0; g < `ETSR_NUM_SAMPLES; g = g + 1) begin : gen_rec
            localparam [31:0] REC_IDX = g;
            reg [31:0] rec_sec;
            reg [29:0] rec_nanos;
            reg [2:0] rec_slot;
            reg rec_pol;
            always @(posedge ref_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    rec_sec <= `ETSR_RESET_WORD; // R02
                    rec_nanos <= 30'h0; // R03
                    rec_slot <= 3'h0;
                    rec_pol <= 1'b0;
                end else if (edge_in && !restart_in && {30'h0, count_out} == REC_IDX) begin
                    rec_sec <= sec_in; // R02
                    rec_nanos <= nanos_in; // R03
                    rec_slot <= slot_code_in; // R05
                    rec_pol <= polarity_in; // R04
                end
            end
            assign sec_out[32*g+31:32*g] = rec_sec;
            assign nanos_out[30*g+29:30*g] = rec_nanos;
            assign slot_out[3*g+2:3*g] = rec_slot;
            assign pol_out[g] = rec_pol;
        end
    endgenerate

    // records fill in order and then hold until software restarts the unit
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_out <= 2'h0;
        end else if (restart_in) begin
            count_out <= 2'h0;
        end else if (edge_in && count_out != 2'h3) begin
            count_out <= count_out + 2'h1;
        end
    end

endmodule

/* core/etsr_top.v */
// timestamp sample record block: edge capture on two units, avalon-mm register view
// assumes event inputs and time base inputs are synchronous to ref_clk_in
//
// Summary of operation
// R01 - unit pointer in bit 8 of unit index register selects visible records
// R02 - seconds words are full 32-bit read-only, reset zero, separate from others
// R03 - nanoseconds sit in bits 29:0 of nanoseconds word, read-only, reset zero
// R04 - bit 30 holds capture edge, one rising, zero falling; bit 31 reserved
// R05 - 3-bit phase field tells which 8 ns slot of 40 ns period
// R06 - codes 000, 001, 011 mean 0 ns, 8 ns, 24 ns slots
// R07 - code 100 means the 32 ns fifth slot
// R08 - third slot, 16 ns, is encoded 010 since 101 is reserved
// R09 - reserved bits read zero, writes to record registers are ignored
`timescale 1ns/1ps
`include "etsr_regs.vh"

module etsr_top (
    // clock and reset
    input wire ref_clk_in,
    input wire reset_n_in,
    // avalon-mm slave
    input wire [11:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    // event inputs, one per timestamp unit
    input wire [1:0] event_in,
    // local time base
    input wire [31:0] time_sec_in,
    input wire [29:0] time_nanos_in,
    // 25 mhz time base marker, one pulse per 40 ns period
    output reg base_tick_out
);

    localparam ST_IDLE = 2'b01;
    localparam ST_ACK = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    reg unit_ptr;
    reg [1:0] restart;
    reg [2:0] slot_cnt;
    reg [1:0] event_prev;
    reg edge_armed;
    reg [1:0] edge_seen;
    reg [1:0] edge_pol;
    reg [31:0] sec_d;
    reg [29:0] nanos_d;
    reg [31:0] next_readdata;
    wire [2:0] slot_code;
    wire [95:0] unit_sec [0:1];
    wire [89:0] unit_nanos [0:1];
    wire [2:0] unit_pol [0:1];
    wire [8:0] unit_slot [0:1];
    wire [1:0] unit_count [0:1];
    wire bus_req;
    wire bus_done;
    wire wr_low_byte;
    wire wr_mid_byte;

    assign bus_req = avs_read_in | avs_write_in;
    assign bus_done = (state == ST_ACK);
    assign wr_low_byte = avs_write_in & bus_done & avs_byteenable_in[0];
    assign wr_mid_byte = avs_write_in & bus_done & avs_byteenable_in[1];

    // slot counter: 125 mhz divided into five 8 ns slots of the 40 ns period
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            slot_cnt <= 3'h0;
            base_tick_out <= 1'b0;
        end else if ({29'h0, slot_cnt} == `ETSR_SLOTS_PER_PERIOD - 1) begin
            slot_cnt <= 3'h0;
            base_tick_out <= 1'b1;
        end else begin
            slot_cnt <= slot_cnt + 3'h1;
            base_tick_out <= 1'b0;
        end
    end

    // phase code is one cycle late, so the edge and time are delayed to match
    etsr_slot_enc u_slot_enc (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .slot_in(slot_cnt),
        .code_out(slot_code)
    );

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            event_prev <= 2'h0;
            edge_armed <= 1'b0;
            edge_seen <= 2'h0;
            edge_pol <= 2'h0;
            sec_d <= `ETSR_RESET_WORD;
            nanos_d <= 30'h0;
        end else begin
            event_prev <= event_in;
            edge_armed <= 1'b1;
            // no compare until the previous level is real: a line idling high
            // would otherwise look like an edge right after reset; an edge in
            // that first cycle is lost
            edge_seen <= edge_armed ? (event_in ^ event_prev) : 2'h0;
            edge_pol <= event_in; // R04
            sec_d <= time_sec_in;
            nanos_d <= time_nanos_in;
        end
    end

    genvar u;
    generate
        for (u = 0; u < `ETSR_NUM_UNITS; u = u + 1) begin : gen_unit
            etsr_capture u_capture (
                .ref_clk_in(ref_clk_in),
                .reset_n_in(reset_n_in),
                .edge_in(edge_seen[u]),
                .polarity_in(edge_pol[u]),
                .restart_in(restart[u]),
                .sec_in(sec_d),
                .nanos_in(nanos_d),
                .slot_code_in(slot_code),
                .sec_out(unit_sec[u]),
                .nanos_out(unit_nanos[u]),
                .pol_out(unit_pol[u]),
                .slot_out(unit_slot[u]),
                .count_out(unit_count[u])
            );
        end
    endgenerate

    // bus handshake: one wait cycle, answer on the cycle after the request
    always @* begin
        case (state)
            ST_IDLE: next_state = bus_req ? ST_ACK : ST_IDLE;
            ST_ACK: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // read mux; unmapped and reserved bits read zero
    always @* begin
        next_readdata = `ETSR_RESET_WORD; // R09
        case (avs_address_in)
            `ETSR_OFS_S5_SEC: begin
                next_readdata = unit_sec[unit_ptr][31:0]; // R01 R02
            end
            `ETSR_OFS_S5_PHASE: begin
                next_readdata[`ETSR_SLOT_MSB:0] = unit_slot[unit_ptr][2:0]; // R05
            end
            `ETSR_OFS_S6_NS: begin
                next_readdata[`ETSR_NS_MSB:0] = unit_nanos[unit_ptr][59:30]; // R03
                next_readdata[`ETSR_NS_POL_BIT] = unit_pol[unit_ptr][1]; // R04
            end
            `ETSR_OFS_S6_SEC: begin
                next_readdata = unit_sec[unit_ptr][63:32]; // R02
            end
            `ETSR_OFS_S6_PHASE: begin
                next_readdata[`ETSR_SLOT_MSB:0] = unit_slot[unit_ptr][5:3]; // R05
            end
            `ETSR_OFS_S7_NS: begin
                next_readdata[`ETSR_NS_MSB:0] = unit_nanos[unit_ptr][89:60]; // R03
                next_readdata[`ETSR_NS_POL_BIT] = unit_pol[unit_ptr][2]; // R04
            end
            `ETSR_OFS_UNIT_INDEX: begin
                next_readdata[`ETSR_UNIT_PTR_BIT] = unit_ptr; // R01
            end
            `ETSR_OFS_CAPTURE_STATUS: begin
                next_readdata[1:0] = unit_count[unit_ptr];
            end
            default: begin
                next_readdata = `ETSR_RESET_WORD; // R09
            end
        endcase
    end

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= ST_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= `ETSR_RESET_WORD;
        end else begin
            state <= next_state;
            avs_waitrequest_out <= !(state == ST_IDLE && bus_req);
            if (state == ST_IDLE && avs_read_in) begin
                avs_readdata_out <= next_readdata;
            end
        end
    end

    // only the unit index register takes writes; record registers ignore them
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            unit_ptr <= 1'b0;
            restart <= 2'h0;
        end else begin
            restart <= 2'h0;
            if (avs_address_in == `ETSR_OFS_UNIT_INDEX) begin
                if (wr_mid_byte) begin
                    unit_ptr <= avs_writedata_in[`ETSR_UNIT_PTR_BIT]; // R01
                end
                if (wr_low_byte && avs_writedata_in[`ETSR_RESTART_BIT]) begin
                    // restart hits the unit selected before this write
                    restart[unit_ptr] <= 1'b1;
                end
            end
        end
    end

endmodule

/* sim/etsr_regs_monitor.sv */
// checker for the sample record block: bus timing, reserved bits, tick period
// assumes only the top's ports, attached by the bind below
`timescale 1ns/1ps
`include "etsr_regs.vh"
module etsr_regs_monitor (
    // clock and reset
    input wire ref_clk_in,
    input wire reset_n_in,
    // register bus
    input wire [11:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    // time base
    input wire base_tick_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    wire [11:0] a = avs_address_in;
    wire done = avs_read_in && !avs_waitrequest_out;
    wire is_ph = a == `ETSR_OFS_S5_PHASE || a == `ETSR_OFS_S6_PHASE;
    wire is_ns = a == `ETSR_OFS_S6_NS || a == `ETSR_OFS_S7_NS;
    wire is_id = a == `ETSR_OFS_UNIT_INDEX || a == `ETSR_OFS_CAPTURE_STATUS;
    wire mapped = is_ph || is_ns || is_id || a == `ETSR_OFS_S5_SEC || a == `ETSR_OFS_S6_SEC;
    chk_wait_once: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low twice");
    chk_wait_cause: assert property ($fell(avs_waitrequest_out) |->
        $past(avs_read_in || avs_write_in)) else $error("answer without request");
    chk_wait_bound: assert property ($rose(avs_read_in || avs_write_in) |->
        ##[1:2] !avs_waitrequest_out) else $error("answer late");
    chk_unmapped_zero: assert property (done && !mapped |-> avs_readdata_out == 0)
        else $error("unmapped read not zero");
    chk_phase_resv: assert property (done && is_ph |-> avs_readdata_out[31:3] == 0)
        else $error("phase upper bits set");
    chk_phase_code: assert property (done && is_ph |-> avs_readdata_out[2:0] <= 3'h4)
        else $error("phase code reserved");
    chk_ns_resv: assert property (done && is_ns |-> !avs_readdata_out[31])
        else $error("nanos bit 31 set");
    chk_ptr_only: assert property (done && a == `ETSR_OFS_UNIT_INDEX |->
        (avs_readdata_out & ~32'h00000100) == 0) else $error("index extra bits");
    chk_tick_period: assert property (base_tick_out |=> !base_tick_out [*4] ##1 base_tick_out)
        else $error("tick period wrong");
    cover property (done && is_ph && avs_readdata_out[2:0] == 3'h4);
    cover property (done && a == `ETSR_OFS_CAPTURE_STATUS && avs_readdata_out[1:0] == 2'h3);
    cover property (avs_write_in && !avs_waitrequest_out);
endmodule
bind etsr_top etsr_regs_monitor mon (.ref_clk_in, .reset_n_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .base_tick_out);

/* sim/etsr_event_src.sv */
// event source standing in for the external timestamp inputs and local time
// assumes strike is called from the bench's main sequence only
`timescale 1ns/1ps
module etsr_event_src (
    // clock
    input wire ref_clk_in,
    // event and time outputs
    output logic [1:0] event_out,
    output logic [31:0] sec_out,
    output logic [29:0] nanos_out
);
    initial begin
        event_out = 2'h0;
        sec_out = 32'h0;
        nanos_out = 30'h0;
    end
    // time inverted after the capture slot so a late sample shows
    task strike(input int u, input logic lvl, input logic [31:0] s, input logic [29:0] n);
        begin
            @(posedge ref_clk_in);
            event_out[u] <= lvl;
            sec_out <= s;
            nanos_out <= n;
            repeat (3) @(posedge ref_clk_in);
            sec_out <= ~s;
            nanos_out <= ~n;
            repeat (2) @(posedge ref_clk_in);
        end
    endtask
endmodule

/* sim/etsr_top_bench.sv */
// self-checking bench for the sample record block
// assumes the monitor is bound and the event source drives events and time
`timescale 1ns/1ps
module etsr_top_bench;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0;
    logic [11:0] addr = 0;
    logic [31:0] wd = 0, q;
    wire [31:0] rdata, tsec;
    wire [29:0] tns;
    wire [1:0] ev;
    wire wait_r, tick;
    int n_fail = 0, num_checks = 0;
    logic [11:0] row_a [9] = '{12'h588, 12'h58c, 12'h590, 12'h594, 12'h598, 12'h59c,
        12'h524, 12'h520, 12'h5a0};
    logic [31:0] row_e [9] = '{default: 32'h0};
    // phase code of each 8 ns slot, first to fifth
    logic [2:0] exp_code [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    etsr_top dut (.ref_clk_in(clk), .reset_n_in(rst_n), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .event_in(ev),
        .time_sec_in(tsec), .time_nanos_in(tns), .base_tick_out(tick));
    etsr_event_src src (.ref_clk_in(clk), .event_out(ev), .sec_out(tsec), .nanos_out(tns));
    initial begin
        forever #4 clk = ~clk;
    end
    task stop_test;
        if (n_fail == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        begin
            k = 0;
            @(posedge clk);
            rd <= !w;
            wr <= w;
            addr <= a;
            wd <= d;
            do begin
                @(posedge clk);
                k++;
            end while (wait_r !== 1'b0 && k < 20);
            q = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
            if (k >= 20) begin
                n_fail++;
                $display("[ERR] %0t bus hang", $time);
                stop_test;
            end
        end
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    initial begin
        int i, k;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 9; i++) rchk(row_a[i], row_e[i]);
        src.strike(0, 1'b1, 32'h11111111, 30'h01010101);
        src.strike(0, 1'b0, 32'h22222222, 30'h02020202);
        src.strike(0, 1'b1, 32'h33333333, 30'h03030303);
        // fourth edge must find the unit full
        src.strike(0, 1'b0, 32'h44444444, 30'h04040404);
        bus(1'b1, 12'h588, 32'hffffffff);
        rchk(12'h588, 32'h11111111);
        rchk(12'h590, 32'h02020202);
        rchk(12'h594, 32'h22222222);
        rchk(12'h59c, 32'h43030303);
        rchk(12'h524, 32'h00000003);
        bus(1'b1, 12'h520, 32'h00000100);
        rchk(12'h520, 32'h00000100);
        rchk(12'h588, 32'h00000000);
        src.strike(1, 1'b1, 32'h55555555, 30'h05050505);
        rchk(12'h588, 32'h55555555);
        bus(1'b1, 12'h520, 32'h00000000);
        rchk(12'h588, 32'h11111111);
        // sweep the event over the five slots after a tick
        for (i = 0; i < 5; i++) begin
            bus(1'b1, 12'h520, 32'h00000001);
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (tick !== 1'b1 && k < 20);
            if (k >= 20) begin
                n_fail++;
                $display("[ERR] %0t no tick", $time);
                stop_test;
            end
            repeat (i) @(posedge clk);
            src.strike(0, ~i[0], 32'h0, 30'h0);
            bus(1'b0, 12'h58c, 32'h0);
            // event first sampled i + 2 edges after the tick was seen, so slot i + 2
            chk(q, {29'h0, exp_code[(i + 2) % 5]});
        end
        // mid-run reset with the event line left high: records clear, no false edge
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rchk(12'h524, 32'h00000000);
        rchk(12'h588, 32'h00000000);
        rchk(12'h590, 32'h00000000);
        rchk(12'h58c, 32'h00000000);
        stop_test;
    end
endmodule
